// >>> core/fps_pkg.sv
// Constants, register map and state codes for the flash erase/program sequencer
//------------------------------------------------------------------------------
// Function
// - Erase clears the whole eight-row page
// - One page spans 512 instructions
// - Row program writes 64 latched instructions
// - Page erase: select 0010 with erase bit
// - No operation runs without the key sequence
// - Go after unlock starts cycle, stalls CPU
// - Hardware clears go when the cycle ends
// - Row program: select 0001, erase bit clear
// - Key register upper byte reads zero
// - Key register low byte is write-only
// - Other select codes perform no operation
// - Table writes fill latch, then pointer increments
// - Failed or improper start sets error flag
//------------------------------------------------------------------------------
package fps_pkg;

	// Bus widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int WORD_W = 24;
	localparam int FADDR_W = 24;

	// Register indices on the plain register port
	localparam logic [3:0] REG_OP_CONTROL = 4'h0;
	localparam logic [3:0] REG_UNLOCK_KEY = 4'h1;
	localparam logic [3:0] REG_PAGE_POINTER = 4'h2;
	localparam logic [3:0] REG_TABLE_OFFSET = 4'h3;
	localparam logic [3:0] REG_WRITE_LOW = 4'h4;
	localparam logic [3:0] REG_WRITE_HIGH = 4'h5;

	// Control register field positions
	localparam int CTL_GO_BIT = 15;
	localparam int CTL_PERMIT_BIT = 14;
	localparam int CTL_ERROR_BIT = 13;
	localparam int CTL_ERASE_BIT = 6;
	localparam int CTL_OP_LSB = 0;
	localparam int CTL_OP_W = 4;

	// Reset values
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] KEY_RESET = 16'h0000;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [15:0] OFFSET_RESET = 16'h0000;

	// Operation select codes
	localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
	localparam logic [3:0] OP_ROW_PROGRAM = 4'h1;

	// Unlock keys
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Geometry: each instruction takes two address units
	localparam int ROW_INSTR = 64;
	localparam int PAGE_ROWS = 8;
	localparam int PAGE_INSTR = ROW_INSTR * PAGE_ROWS;
	localparam int ROW_ALIGN_BITS = 7;
	localparam int PAGE_ALIGN_BITS = 10;
	localparam logic [15:0] INSTR_STEP = 16'h0002;

	// Clock
	localparam int CLK_PERIOD_NS = 8;

	// Minimum-time conversion, rounded up and never below one cycle
	function automatic int us_to_cycles(input int t_us);
		int c;
		c = (t_us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Key tracking states
	typedef enum logic [1:0] {
		FPS_KEY_IDLE = 2'b00,
		FPS_KEY_FIRST = 2'b01,
		FPS_KEY_ARMED = 2'b11
	} fps_key_e;

	// Operation states, Gray along idle-stream-wait-done
	typedef enum logic [1:0] {
		FPS_OP_IDLE = 2'b00,
		FPS_OP_STREAM = 2'b01,
		FPS_OP_WAIT = 2'b11,
		FPS_OP_DONE = 2'b10
	} fps_op_e;

endpackage

// >>> core/fps_latch_if.sv
// Interface between the sequencer and its program holding latches
`timescale 1ns/100ps
interface fps_latch_if #(
	parameter int IDX_W = 6
);
	logic [IDX_W-1:0] wr_idx; // Latch selected by the table pointer
	logic wr_low; // Load low instruction word
	logic wr_high; // Load high instruction byte
	logic [15:0] wr_low_data; // Low word data
	logic [7:0] wr_high_data; // High byte data
	logic [IDX_W-1:0] rd_idx; // Latch read during row program
	logic [23:0] rd_data; // Registered read data, one cycle later

	// Sequencer side
	modport seq (
		output wr_idx, wr_low, wr_high, wr_low_data, wr_high_data, rd_idx,
		input rd_data
	);

	// Latch array side
	modport mem (
		input wr_idx, wr_low, wr_high, wr_low_data, wr_high_data, rd_idx,
		output rd_data
	);
endinterface

// >>> core/fps_latch_buf.sv
// Program holding latches: one row of instructions, low word and high byte
`timescale 1ns/100ps
module fps_latch_buf #(
	parameter int DEPTH = 64,
	parameter int IDX_W = 6
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Latch port
	fps_latch_if.mem lat
);
	// Refuse a depth that the index cannot address exactly
	if (DEPTH != (1 << IDX_W)) begin : g_chk
		$error("fps_latch_buf: DEPTH must equal 2**IDX_W");
	end

	logic [23:0] mem [DEPTH]; // Latch storage, left as written between rows
	logic [23:0] rd_q; // Registered read

	// Low word and high byte load separately, as the two table writes do
	always_ff @(posedge i_clk) begin
		if (lat.wr_low) begin
			mem[lat.wr_idx][15:0] <= lat.wr_low_data;
		end
		if (lat.wr_high) begin
			mem[lat.wr_idx][23:16] <= lat.wr_high_data;
		end
	end

	// Read one cycle after the index is presented
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rd_q <= 24'h000000;
		end else begin
			rd_q <= mem[lat.rd_idx];
		end
	end

	assign lat.rd_data = rd_q;
endmodule

// >>> core/fps_cycle_timer.sv
// Down counter that times one erase or program cell cycle
`timescale 1ns/100ps
module fps_cycle_timer #(
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Control
	input wire logic i_load,
	input wire logic [CNT_W-1:0] i_cycles,
	// Status
	output logic o_done
);
	if (CNT_W < 2) begin : g_chk
		$error("fps_cycle_timer: CNT_W too small");
	end

	logic [CNT_W-1:0] count; // Cycles left
	logic running; // Timing in progress
	wire last = running && (count == {{(CNT_W-1){1'b0}}, 1'b1});

	// Load starts timing; done pulses in the cycle after the last count
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			count <= '0;
			running <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= last;
			if (i_load) begin
				count <= i_cycles;
				running <= 1'b1;
			end else if (last) begin
				count <= '0;
				running <= 1'b0;
			end else if (running) begin
				count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// >>> core/fps_sequencer.sv
// Flash erase/program sequencer top: registers, unlock, operation control
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module fps_sequencer #(
	parameter int ERASE_TIME_US = 20000,
	parameter int PROG_TIME_US = 2000,
	parameter int ERASE_CYCLES = fps_pkg::us_to_cycles(ERASE_TIME_US),
	parameter int PROG_CYCLES = fps_pkg::us_to_cycles(PROG_TIME_US)
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register port
	input wire logic [fps_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fps_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [fps_pkg::DATA_W-1:0] o_rdata,
	// Flash array side
	output logic [fps_pkg::FADDR_W-1:0] o_flash_addr,
	output logic o_flash_erase,
	output logic o_flash_prog,
	output logic [fps_pkg::WORD_W-1:0] o_flash_wdata,
	output logic o_flash_wstrobe,
	// CPU side
	output logic o_cpu_stall
);
	//--------------------------------------------------------------------------
	// Elaboration checks
	//--------------------------------------------------------------------------
	if (ERASE_CYCLES < 1 || PROG_CYCLES < 1) begin : g_chk
		$error("fps_sequencer: cycle counts must be at least one");
	end

	localparam int IDX_W = 6; // Row latch index width
	localparam int CNT_W = 32; // Timer width
	localparam logic [CNT_W-1:0] ERASE_CNT = CNT_W'(ERASE_CYCLES);
	localparam logic [CNT_W-1:0] PROG_CNT = CNT_W'(PROG_CYCLES);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(fps_pkg::ROW_INSTR - 1);

	//--------------------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------------------
	logic go; // Operation in progress, cleared by hardware
	logic write_permit; // Software permit for erase/program
	logic sequence_error_flag; // Sticky improper-start flag
	logic erase_sel; // Erase when set, program when clear
	logic [3:0] flash_op_select; // Operation code
	logic [7:0] table_page_pointer; // Upper address byte
	logic [15:0] table_offset; // In-page pointer, post-increments
	logic [fps_pkg::FADDR_W-1:0] latch_addr; // Pointer at the last latch load
	fps_pkg::fps_key_e key_state; // Unlock progress
	fps_pkg::fps_op_e op_state; // Operation progress
	logic [IDX_W-1:0] rd_idx; // Next latch to stream
	logic pend; // Latch data arrives this cycle
	logic [IDX_W-1:0] pend_idx; // Index of the arriving data
	logic [fps_pkg::FADDR_W-1:0] op_base; // Page or row base address
	logic timer_load; // Start cell timing
	logic [CNT_W-1:0] timer_cycles; // Count for cell timing
	logic timer_done; // Cell timing complete

	//--------------------------------------------------------------------------
	// Decode
	//--------------------------------------------------------------------------
	wire idle = (op_state == fps_pkg::FPS_OP_IDLE);
	wire wr_ctl = i_wr && (i_addr == fps_pkg::REG_OP_CONTROL) && idle;
	wire wr_key = i_wr && (i_addr == fps_pkg::REG_UNLOCK_KEY);
	wire wr_page = i_wr && (i_addr == fps_pkg::REG_PAGE_POINTER) && idle;
	wire wr_offs = i_wr && (i_addr == fps_pkg::REG_TABLE_OFFSET) && idle;
	wire wr_low = i_wr && (i_addr == fps_pkg::REG_WRITE_LOW) && idle;
	wire wr_high = i_wr && (i_addr == fps_pkg::REG_WRITE_HIGH) && idle;
	wire [3:0] w_op = i_wdata[fps_pkg::CTL_OP_LSB +: fps_pkg::CTL_OP_W];
	wire w_erase = i_wdata[fps_pkg::CTL_ERASE_BIT];
	wire w_permit = i_wdata[fps_pkg::CTL_PERMIT_BIT];
	wire go_req = wr_ctl && i_wdata[fps_pkg::CTL_GO_BIT];
	wire armed = (key_state == fps_pkg::FPS_KEY_ARMED);
	// Only the two documented codes name an operation; the rest do nothing
	wire is_erase = w_erase && (w_op == fps_pkg::OP_PAGE_ERASE);
	wire is_prog = !w_erase && (w_op == fps_pkg::OP_ROW_PROGRAM);
	// Start needs the keys immediately before and the permit bit
	wire start = go_req && armed && w_permit && (is_erase || is_prog);
	wire start_erase = start && is_erase;
	wire start_prog = start && is_prog;
	// A go attempt without unlock or permit is a failed set attempt
	wire fail = go_req && !(armed && w_permit);
	wire [fps_pkg::FADDR_W-1:0] cur_addr = {table_page_pointer, table_offset};
	wire stream_last = (op_state == fps_pkg::FPS_OP_STREAM) && (rd_idx == LAST_IDX);
	wire [15:0] next_offset = table_offset + fps_pkg::INSTR_STEP;

	// Base address aligned to the page for erase, the row for program
	function automatic logic [fps_pkg::FADDR_W-1:0] align(
		input logic [fps_pkg::FADDR_W-1:0] a, input int bits);
		logic [fps_pkg::FADDR_W-1:0] m;
		m = '1;
		m = m << bits;
		return a & m;
	endfunction

	wire [fps_pkg::FADDR_W-1:0] page_base = align(cur_addr, fps_pkg::PAGE_ALIGN_BITS);
	wire [fps_pkg::FADDR_W-1:0] row_base = align(latch_addr, fps_pkg::ROW_ALIGN_BITS);

	// Readback: key reads zero, unmapped reads zero
	wire [15:0] ctl_rd = {go, write_permit, sequence_error_flag, 6'h00, erase_sel,
		2'h0, flash_op_select};
	wire [15:0] next_rdata =
		(i_addr == fps_pkg::REG_OP_CONTROL) ? ctl_rd :
		(i_addr == fps_pkg::REG_PAGE_POINTER) ? {8'h00, table_page_pointer} :
		(i_addr == fps_pkg::REG_TABLE_OFFSET) ? table_offset :
		16'h0000;

	//--------------------------------------------------------------------------
	// Latches and timer
	//--------------------------------------------------------------------------
	fps_latch_if #(.IDX_W(IDX_W)) lat_if ();

	assign lat_if.wr_idx = table_offset[IDX_W:1];
	assign lat_if.wr_low = wr_low;
	assign lat_if.wr_high = wr_high;
	assign lat_if.wr_low_data = i_wdata;
	assign lat_if.wr_high_data = i_wdata[7:0];
	assign lat_if.rd_idx = rd_idx;

	fps_latch_buf #(
		.DEPTH(fps_pkg::ROW_INSTR),
		.IDX_W(IDX_W)
	) u_latch (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.lat(lat_if.mem)
	);

	fps_cycle_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_load(timer_load),
		.i_cycles(timer_cycles),
		.o_done(timer_done)
	);

	//--------------------------------------------------------------------------
	// Read data
	//--------------------------------------------------------------------------
	// Data stands only in the cycle after the read strobe
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata <= 16'h0000;
		end else begin
			o_rdata <= i_rd ? next_rdata : 16'h0000;
		end
	end

	//--------------------------------------------------------------------------
	// Unlock key tracking
	//--------------------------------------------------------------------------
	// Any write other than the next key drops the unlock, so a go attempt
	// always consumes it and stray writes in between void the sequence
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			key_state <= fps_pkg::FPS_KEY_IDLE;
		end else if (wr_key && i_wdata[7:0] == fps_pkg::KEY_FIRST) begin
			key_state <= fps_pkg::FPS_KEY_FIRST;
		end else if (wr_key && i_wdata[7:0] == fps_pkg::KEY_SECOND &&
			key_state == fps_pkg::FPS_KEY_FIRST) begin
			key_state <= fps_pkg::FPS_KEY_ARMED;
		end else if (i_wr) begin
			key_state <= fps_pkg::FPS_KEY_IDLE;
		end
	end

	//--------------------------------------------------------------------------
	// Control register
	//--------------------------------------------------------------------------
	// Fields load on a control write while idle; busy writes are ignored
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			write_permit <= fps_pkg::CTL_RESET[fps_pkg::CTL_PERMIT_BIT];
			erase_sel <= fps_pkg::CTL_RESET[fps_pkg::CTL_ERASE_BIT];
			flash_op_select <= fps_pkg::CTL_RESET[3:0];
		end else if (wr_ctl) begin
			write_permit <= w_permit;
			erase_sel <= w_erase;
			flash_op_select <= w_op;
		end
	end

	// Go sets only on a valid start and clears itself at the end
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			go <= fps_pkg::CTL_RESET[fps_pkg::CTL_GO_BIT];
		end else if (start) begin
			go <= 1'b1;
		end else if (op_state == fps_pkg::FPS_OP_DONE) begin
			go <= 1'b0;
		end
	end

	// Error flag: set wins over a software clear in the same write
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sequence_error_flag <= fps_pkg::CTL_RESET[fps_pkg::CTL_ERROR_BIT];
		end else if (fail) begin
			sequence_error_flag <= 1'b1;
		end else if (wr_ctl && !i_wdata[fps_pkg::CTL_ERROR_BIT]) begin
			sequence_error_flag <= 1'b0;
		end
	end

	//--------------------------------------------------------------------------
	// Table pointer
	//--------------------------------------------------------------------------
	// High-byte write completes an instruction and advances the pointer
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			table_page_pointer <= fps_pkg::PAGE_RESET;
			table_offset <= fps_pkg::OFFSET_RESET;
			latch_addr <= '0;
		end else begin
			if (wr_page) begin
				table_page_pointer <= i_wdata[7:0];
			end
			// Keep the loaded row: the pointer has moved past it by go time
			if (wr_low || wr_high) begin
				latch_addr <= cur_addr;
			end
			if (wr_offs) begin
				table_offset <= i_wdata;
			end else if (wr_high) begin
				table_offset <= next_offset;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Operation sequencing
	//--------------------------------------------------------------------------
	// Erase goes straight to timing; program streams the row latches first
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			op_state <= fps_pkg::FPS_OP_IDLE;
			rd_idx <= '0;
			op_base <= '0;
		end else begin
			unique case (op_state)
				fps_pkg::FPS_OP_IDLE: begin
					rd_idx <= '0;
					if (start_erase) begin
						op_base <= page_base;
						op_state <= fps_pkg::FPS_OP_WAIT;
					end else if (start_prog) begin
						op_base <= row_base;
						op_state <= fps_pkg::FPS_OP_STREAM;
					end
				end
				fps_pkg::FPS_OP_STREAM: begin
					rd_idx <= rd_idx + 1'b1;
					if (stream_last) begin
						op_state <= fps_pkg::FPS_OP_WAIT;
					end
				end
				fps_pkg::FPS_OP_WAIT: begin
					if (timer_done) begin
						op_state <= fps_pkg::FPS_OP_DONE;
					end
				end
				fps_pkg::FPS_OP_DONE: begin
					op_state <= fps_pkg::FPS_OP_IDLE;
				end
			endcase
		end
	end

	// Timer loads at an erase start or after the last latch is issued
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			timer_load <= 1'b0;
			timer_cycles <= '0;
		end else begin
			timer_load <= start_erase || stream_last;
			timer_cycles <= start_erase ? ERASE_CNT : PROG_CNT;
		end
	end

	// Latch read data lags the index by one cycle
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pend <= 1'b0;
			pend_idx <= '0;
		end else begin
			pend <= (op_state == fps_pkg::FPS_OP_STREAM);
			pend_idx <= rd_idx;
		end
	end

	//--------------------------------------------------------------------------
	// Flash array and CPU outputs
	//--------------------------------------------------------------------------
	// CPU stalls from the start until the go bit drops
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_cpu_stall <= 1'b0;
			o_flash_erase <= 1'b0;
			o_flash_prog <= 1'b0;
		end else begin
			if (start) begin
				o_cpu_stall <= 1'b1;
			end else if (op_state == fps_pkg::FPS_OP_DONE) begin
				o_cpu_stall <= 1'b0;
			end
			o_flash_erase <= start_erase ||
				(o_flash_erase && op_state != fps_pkg::FPS_OP_DONE);
			o_flash_prog <= start_prog ||
				(o_flash_prog && op_state != fps_pkg::FPS_OP_DONE);
		end
	end

	// Address shows the page base for erase and each row word while streaming
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_flash_addr <= '0;
			o_flash_wdata <= '0;
			o_flash_wstrobe <= 1'b0;
		end else begin
			o_flash_wstrobe <= pend;
			if (start_erase) begin
				o_flash_addr <= page_base;
			end else if (pend) begin
				o_flash_addr <= op_base | {{(fps_pkg::FADDR_W-IDX_W-1){1'b0}}, pend_idx, 1'b0};
				o_flash_wdata <= lat_if.rd_data;
			end
		end
	end
endmodule

// >>> tb/fps_sequencer_properties.sv
// Port-level checks for the flash erase/program sequencer
`timescale 1ns/100ps
module fps_sequencer_properties #(
	parameter int ERASE_CYCLES = 20,
	parameter int PROG_CYCLES = 10
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register port
	input wire logic [fps_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fps_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [fps_pkg::DATA_W-1:0] o_rdata,
	// Flash array and CPU side
	input wire logic [fps_pkg::FADDR_W-1:0] o_flash_addr,
	input wire logic o_flash_erase,
	input wire logic o_flash_prog,
	input wire logic [fps_pkg::WORD_W-1:0] o_flash_wdata,
	input wire logic o_flash_wstrobe,
	input wire logic o_cpu_stall
);
	// Longest busy span; slack covers streaming and the done handshake
	localparam int SPAN = ERASE_CYCLES + PROG_CYCLES + 80;
	localparam int E_LO = ERASE_CYCLES - 1;
	localparam int E_HI = ERASE_CYCLES + 4;
	int erase_len; // Cycles the erase level has stood so far
	int strobe_cnt; // Word strobes inside the current program cycle
	wire logic [7:0] key_byte = i_wdata[7:0]; // Byte the key register takes
	wire logic go_bit = i_wdata[15]; // Go request in a control write

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	//--------------------------------------------------------------
	// Helper counters
	//--------------------------------------------------------------
	// Both counters drop to zero once their level falls
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			erase_len <= 0;
			strobe_cnt <= 0;
		end else begin
			erase_len <= o_flash_erase ? erase_len + 1 : 0;
			strobe_cnt <= !o_flash_prog ? 0 : strobe_cnt + int'(o_flash_wstrobe);
		end
	end

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	a_erase_page_base: assert property ($rose(o_flash_erase) |-> o_flash_addr[9:0] == 10'h000)
		else $error("erase started off a page boundary");
	a_erase_length: assert property ($fell(o_flash_erase) |-> erase_len inside {[E_LO:E_HI]})
		else $error("erase cycle length wrong");
	a_row_word_count: assert property ($fell(o_flash_prog) |-> strobe_cnt == 64)
		else $error("row program did not stream 64 words");
	a_strobe_in_prog: assert property (o_flash_wstrobe |-> o_flash_prog && !o_flash_addr[0])
		else $error("word strobe outside a program cycle");
	a_one_op_only: assert property (!(o_flash_erase && o_flash_prog))
		else $error("erase and program at once");
	a_stall_covers_op: assert property ((o_flash_erase || o_flash_prog) |-> o_cpu_stall)
		else $error("flash busy without CPU stall");
	a_start_after_keys: assert property ($rose(o_cpu_stall) |->
		$past(i_wr) && $past(go_bit) && $past(i_addr) == fps_pkg::REG_OP_CONTROL &&
		$past(i_wr, 2) && $past(i_addr, 2) == fps_pkg::REG_UNLOCK_KEY &&
		$past(key_byte, 2) == 8'haa && $past(i_wr, 3) && $past(key_byte, 3) == 8'h55 &&
		$past(i_addr, 3) == fps_pkg::REG_UNLOCK_KEY)
		else $error("operation started without key sequence");
	a_go_self_clears: assert property ($rose(o_cpu_stall) |-> ##[1:SPAN] !o_cpu_stall)
		else $error("go never cleared");
	a_key_reads_zero: assert property (i_rd && i_addr == fps_pkg::REG_UNLOCK_KEY |=>
		o_rdata == 16'h0000)
		else $error("key register read back nonzero");
endmodule

bind fps_sequencer fps_sequencer_properties #(
	.ERASE_CYCLES(ERASE_CYCLES),
	.PROG_CYCLES(PROG_CYCLES)
) u_fps_sequencer_properties (
	.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_flash_addr(o_flash_addr),
	.o_flash_erase(o_flash_erase), .o_flash_prog(o_flash_prog),
	.o_flash_wdata(o_flash_wdata), .o_flash_wstrobe(o_flash_wstrobe),
	.o_cpu_stall(o_cpu_stall)
);

// >>> tb/fps_sequencer_tb_top.sv
// Self-checking testbench for the flash erase/program sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module fps_sequencer_tb_top;
	logic i_clk, i_reset, i_wr, i_rd;
	logic [fps_pkg::ADDR_W-1:0] i_addr;
	logic [fps_pkg::DATA_W-1:0] i_wdata, o_rdata, lfsr, page, off;
	logic [fps_pkg::FADDR_W-1:0] o_flash_addr;
	logic [fps_pkg::WORD_W-1:0] o_flash_wdata;
	logic o_flash_erase, o_flash_prog, o_flash_wstrobe, o_cpu_stall;
	logic [15:0] lo [64]; // Latch low words as loaded
	logic [7:0] hi [64]; // Latch high bytes as loaded
	int mismatches = 0;
	int tests_run = 0;
	int nstr; // Word strobes seen in the last operation

	// Short cell times keep the run brief
	fps_sequencer #(.ERASE_CYCLES(20), .PROG_CYCLES(10)) u_fps_sequencer (
		.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_flash_addr(o_flash_addr),
		.o_flash_erase(o_flash_erase), .o_flash_prog(o_flash_prog),
		.o_flash_wdata(o_flash_wdata), .o_flash_wstrobe(o_flash_wstrobe),
		.o_cpu_stall(o_cpu_stall));

	// 125 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	//--------------------------------------------------------------
	// Expectation helpers and bus tasks
	//--------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Control word: go, permit, error, erase select, op select
	function automatic logic [15:0] ctl(input logic g, p, e, x, input logic [3:0] op);
		return {g, p, e, 6'h00, x, 2'b00, op};
	endfunction
	// Erase always lands on the 1024-unit page holding the pointer
	function automatic logic [23:0] erase_base(input logic [15:0] pg, of);
		return {pg[7:0], of[15:10], 10'h000};
	endfunction
	task automatic rnd();
		lfsr = lfsr_next(lfsr);
	endtask
	// Write strobe is left high so writes may run back to back
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask
	task automatic idle();
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		i_rd <= 1'b1;
		i_wr <= 1'b0;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		`CHK(o_rdata, e)
		@(posedge i_clk);
	endtask
	task automatic unlock();
		wr(fps_pkg::REG_UNLOCK_KEY, 16'h0055);
		wr(fps_pkg::REG_UNLOCK_KEY, 16'h00aa);
	endtask
	task automatic launch(input logic [15:0] c, input logic keys, input logic exp);
		if (keys) begin
			unlock();
		end
		wr(fps_pkg::REG_OP_CONTROL, c);
		idle();
		@(negedge i_clk);
		`CHK(o_cpu_stall, exp)
		@(posedge i_clk);
	endtask
	// Waits out a busy cycle, checking each streamed word on the way
	task automatic wait_idle();
		nstr = 0;
		repeat (400) begin
			@(negedge i_clk);
			if (o_flash_wstrobe === 1'b1) begin
				`CHK(o_flash_addr, {page[7:0], off[15:7], 7'(2 * nstr)})
				`CHK(o_flash_prog, 1'b1)
				`CHK(o_flash_wdata, {hi[nstr], lo[nstr]})
				nstr++;
			end
			if (o_cpu_stall !== 1'b1) break;
		end
		`CHK(o_cpu_stall, 1'b0)
		@(posedge i_clk);
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog: far beyond the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		give_verdict();
	end

	//--------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------
	initial begin
		i_reset = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		lfsr = 16'hb2d3;
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		rd(fps_pkg::REG_OP_CONTROL, 16'h0000);
		rd(fps_pkg::REG_UNLOCK_KEY, 16'h0000);
		rd(4'hf, 16'h0000);
		rnd();
		wr(fps_pkg::REG_UNLOCK_KEY, lfsr);
		rd(fps_pkg::REG_UNLOCK_KEY, 16'h0000);
		// Bad starts: no keys, swapped keys, keys interrupted, no permit
		for (int k = 0; k < 4; k++) begin
			if (k == 1) begin
				wr(fps_pkg::REG_UNLOCK_KEY, 16'h00aa);
				wr(fps_pkg::REG_UNLOCK_KEY, 16'h0055);
			end
			if (k == 2) begin
				unlock();
				wr(fps_pkg::REG_PAGE_POINTER, 16'h0000);
			end
			launch(ctl(1'b1, k != 3, 1'b0, 1'b0, 4'h1), k == 3, 1'b0);
			rd(fps_pkg::REG_OP_CONTROL, ctl(1'b0, k != 3, 1'b1, 1'b0, 4'h1));
			wr(fps_pkg::REG_OP_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h1));
			rd(fps_pkg::REG_OP_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h1));
		end
		// Every unlisted select code is inert even when armed
		for (int m = 0; m < 32; m++) begin
			if (m == 18 || m == 1) continue;
			launch(ctl(1'b1, 1'b1, 1'b0, m[4], m[3:0]), 1'b1, 1'b0);
			rd(fps_pkg::REG_OP_CONTROL, ctl(1'b0, 1'b1, 1'b0, m[4], m[3:0]));
		end
		// The last armed go spent the keys
		launch(ctl(1'b1, 1'b1, 1'b0, 1'b1, 4'h2), 1'b0, 1'b0);
		rd(fps_pkg::REG_OP_CONTROL, ctl(1'b0, 1'b1, 1'b1, 1'b1, 4'h2));
		// Page erase at a random pointer; a busy write must not land
		rnd();
		page = lfsr;
		rnd();
		off = lfsr;
		wr(fps_pkg::REG_PAGE_POINTER, {8'h00, page[7:0]});
		wr(fps_pkg::REG_TABLE_OFFSET, off);
		launch(ctl(1'b1, 1'b1, 1'b0, 1'b1, 4'h2), 1'b1, 1'b1);
		@(negedge i_clk);
		`CHK(o_flash_erase, 1'b1)
		`CHK(o_flash_prog, 1'b0)
		`CHK(o_flash_addr, erase_base(page, off))
		@(posedge i_clk);
		wr(fps_pkg::REG_OP_CONTROL, 16'h0000);
		idle();
		wait_idle();
		`CHK(nstr, 0)
		rd(fps_pkg::REG_OP_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b1, 4'h2));
		// Two rows of random latch data programmed one after another
		for (int r = 0; r < 2; r++) begin
			rnd();
			off = (r == 0) ? (lfsr & 16'hff80) : off + 16'h0080;
			wr(fps_pkg::REG_TABLE_OFFSET, off);
			for (int i = 0; i < 64; i++) begin
				rnd();
				lo[i] = lfsr;
				rnd();
				hi[i] = lfsr[7:0];
				wr(fps_pkg::REG_WRITE_LOW, lo[i]);
				wr(fps_pkg::REG_WRITE_HIGH, {8'h00, hi[i]});
			end
			launch(ctl(1'b1, 1'b1, 1'b0, 1'b0, 4'h1), 1'b1, 1'b1);
			wait_idle();
			`CHK(nstr, 64)
			rd(fps_pkg::REG_OP_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h1));
		end
		give_verdict();
	end
endmodule
